// ### inc/rtc_time_pkg.sv
// constants for the rtc time counters and interval alarm
// assumes byte-wide special function register access from the on-chip mcu
package rtc_time_pkg;
  localparam logic [7:0] LOWER_TIME_UNIT_ADDR      = 8'ha3;
  localparam logic [7:0] MIDDLE_TIME_UNIT_ADDR     = 8'ha4;
  localparam logic [7:0] UPPER_TIME_UNIT_ADDR      = 8'ha5;
  localparam logic [7:0] ALARM_INTERVAL_ADDR       = 8'ha6;
  localparam logic [7:0] CRYSTAL_NOMINAL_TRIM_ADDR = 8'hf6;
  localparam logic [7:0] CRYSTAL_THERMAL_TRIM_ADDR = 8'hf7;
  localparam logic [7:0] REG_RESET_VALUE           = 8'h00;
  // 32768 / 128 ticks of the calibrated clock per fraction tick
  localparam logic [7:0] PRESCALE_LAST             = 8'hff;
  localparam logic [7:0] FRACTION_LAST             = 8'h7f;
  localparam logic [7:0] MINSEC_LAST               = 8'h3b;
  localparam logic [7:0] HOUR24_LAST               = 8'h17;
  localparam logic [7:0] HOUR256_LAST              = 8'hff;
  // trim lsb is 2 ppm, so 248 ppm is 124 lsb
  localparam int         TRIM_PPM_PER_LSB          = 2;
  localparam int         TRIM_LIMIT_PPM            = 248;
  localparam logic signed [8:0] TRIM_LIMIT_LSB     = 9'(TRIM_LIMIT_PPM / TRIM_PPM_PER_LSB);
  typedef enum logic [1:0] {
    TB_FRACTION = 2'b00,
    TB_SECOND   = 2'b01,
    TB_MINUTE   = 2'b10,
    TB_HOUR     = 2'b11
  } timebase_t;
endpackage

// ### core/rtc_trim_sum.sv
// adds the nominal and thermal trims and limits the correction
// assumes both trims are twos-complement, 2 ppm per lsb
`timescale 1ns/10ps
`default_nettype none
module rtc_trim_sum
  import rtc_time_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic        [7:0] nominal_trim,
  input  wire logic        [7:0] thermal_trim,
  output logic signed      [7:0] trim_correction
);
  logic signed [8:0] raw_sum;
  logic signed [7:0] nxt_correction;
  logic signed [7:0] correction_ff;

  assign raw_sum = $signed({nominal_trim[7], nominal_trim})
                 + $signed({thermal_trim[7], thermal_trim});

  always_comb begin
    if (raw_sum > TRIM_LIMIT_LSB) begin
      nxt_correction = TRIM_LIMIT_LSB[7:0];
    end else if (raw_sum < -TRIM_LIMIT_LSB) begin
      nxt_correction = 8'(-TRIM_LIMIT_LSB);
    end else begin
      nxt_correction = raw_sum[7:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      correction_ff <= '0;
    end else begin
      correction_ff <= nxt_correction;
    end
  end

  assign trim_correction = correction_ff;

  a_trim_limit_hi: assert property (@(posedge clk) disable iff (sys_rst)
    raw_sum > TRIM_LIMIT_LSB |=> correction_ff == TRIM_LIMIT_LSB[7:0])
    else $error("trim correction not limited high");
  a_trim_limit_lo: assert property (@(posedge clk) disable iff (sys_rst)
    raw_sum < -TRIM_LIMIT_LSB |=> correction_ff == 8'(-TRIM_LIMIT_LSB))
    else $error("trim correction not limited low");
endmodule
`default_nettype wire

// ### core/rtc_time_counters_alarm.sv
// rtc time counters, interval alarm and crystal trim registers
// assumes sys_rst is power-on reset; mcu_rst is watchdog/external reset on clk
// Contract
// - seconds step each second, wrap 59 to 00, carry into minutes
// - minutes step each minute, wrap 59 to 00, carry into hours
// - day mode set: hours wrap 23 to 00, set rollover flag, raise irq
// - day mode clear: hours wrap 255 to 00, set rollover flag, raise irq
// - time and trim registers survive mcu reset; trims clear on power-on only, time registers also while rtc_enable is low
// - interval count equal to alarm interval sets alarm flag and raises irq
// - interval counter and alarm interval register are eight bits
// - nominal trim register written by software, used for correction
// - correction is nominal plus thermal trim, limited to 248 ppm
// - timebase select 00 fraction, 01 second, 10 minute, 11 hour
// - after alarm counter restarts, or is held cleared when single shot
// - seconds step when the 1/128 s fraction counter wraps 127 to 00
`timescale 1ns/10ps
`default_nettype none
module rtc_time_counters_alarm
  import rtc_time_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        mcu_rst,
  input  wire logic        cal_clk_32k,
  input  wire logic  [7:0] sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic  [7:0] sfr_wdata,
  output logic       [7:0] sfr_rdata,
  input  wire logic        rtc_enable,
  input  wire logic        interval_enable,
  input  wire logic        day_mode_select,
  input  wire logic  [1:0] timebase_sel,
  input  wire logic        single_shot_alarm,
  input  wire logic        day_rollover_clr,
  input  wire logic        alarm_clr,
  output logic             day_rollover_flag,
  output logic             alarm_flag,
  output logic             rtc_irq_pending,
  output logic       [7:0] fraction_tick_count,
  output logic signed [7:0] trim_correction
);
  logic       cal_meta_ff;
  logic       cal_sync_ff;
  logic       cal_prev_ff;
  logic       tick_32k;
  logic [7:0] prescale_ff;
  logic [7:0] fraction_ff;
  logic [7:0] lower_ff;
  logic [7:0] middle_ff;
  logic [7:0] upper_ff;
  logic [7:0] interval_ff;
  logic [7:0] nominal_ff;
  logic [7:0] thermal_ff;
  logic [7:0] icount_ff;
  logic       ihold_ff;
  logic       rollover_ff;
  logic       alarm_ff;
  logic       irq_ff;
  logic [7:0] rdata_ff;
  logic       frac_tick;
  logic       sec_tick;
  logic       min_tick;
  logic       hour_tick;
  logic       midnight_evt;
  logic       itb_tick;
  logic       alarm_evt;
  logic [7:0] hour_last;
  logic [7:0] nxt_icount;
  logic [7:0] nxt_rdata;

  function automatic logic [7:0] wrap_inc(input logic [7:0] val, input logic [7:0] last);
    wrap_inc = (val == last) ? 8'h00 : 8'(val + 8'h01);
  endfunction

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction

  // two flops before the edge detector; the first flop feeds nothing else
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cal_meta_ff <= 1'b0;
      cal_sync_ff <= 1'b0;
      cal_prev_ff <= 1'b0;
    end else begin
      cal_meta_ff <= cal_clk_32k;
      cal_sync_ff <= cal_meta_ff;
      cal_prev_ff <= cal_sync_ff;
    end
  end

  assign tick_32k = cal_sync_ff & ~cal_prev_ff & rtc_enable;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prescale_ff <= '0;
    end else if (!rtc_enable) begin
      prescale_ff <= '0;
    end else if (tick_32k) begin
      prescale_ff <= wrap_inc(prescale_ff, PRESCALE_LAST);
    end
  end

  assign frac_tick    = tick_32k && (prescale_ff == PRESCALE_LAST);
  assign sec_tick     = frac_tick && (fraction_ff == FRACTION_LAST);
  assign min_tick     = sec_tick && (lower_ff == MINSEC_LAST);
  assign hour_last    = day_mode_select ? HOUR24_LAST : HOUR256_LAST;
  assign hour_tick    = min_tick && (middle_ff == MINSEC_LAST);
  assign midnight_evt = hour_tick && (upper_ff == hour_last);

  // fraction counter sits under the seconds; not a mapped register here
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fraction_ff <= '0;
    end else if (!rtc_enable) begin
      fraction_ff <= '0;
    end else if (frac_tick) begin
      fraction_ff <= wrap_inc(fraction_ff, FRACTION_LAST);
    end
  end

  // time registers: cleared by power-on or rtc_enable low, mcu_rst deliberately not in this block
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lower_ff  <= REG_RESET_VALUE;
      middle_ff <= REG_RESET_VALUE;
      upper_ff  <= REG_RESET_VALUE;
    end else if (!rtc_enable) begin
      lower_ff  <= REG_RESET_VALUE;
      middle_ff <= REG_RESET_VALUE;
      upper_ff  <= REG_RESET_VALUE;
    end else begin
      // software write beats a tick landing in the same cycle
      if (sfr_wr && hit(sfr_addr, LOWER_TIME_UNIT_ADDR)) begin
        lower_ff <= sfr_wdata;
      end else if (sec_tick) begin
        lower_ff <= wrap_inc(lower_ff, MINSEC_LAST);
      end
      if (sfr_wr && hit(sfr_addr, MIDDLE_TIME_UNIT_ADDR)) begin
        middle_ff <= sfr_wdata;
      end else if (min_tick) begin
        middle_ff <= wrap_inc(middle_ff, MINSEC_LAST);
      end
      if (sfr_wr && hit(sfr_addr, UPPER_TIME_UNIT_ADDR)) begin
        upper_ff <= sfr_wdata;
      end else if (hour_tick) begin
        upper_ff <= wrap_inc(upper_ff, hour_last);
      end
    end
  end

  // trim registers, also power-on only
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      nominal_ff <= REG_RESET_VALUE;
      thermal_ff <= REG_RESET_VALUE;
    end else begin
      if (sfr_wr && hit(sfr_addr, CRYSTAL_NOMINAL_TRIM_ADDR)) begin
        nominal_ff <= sfr_wdata;
      end
      if (sfr_wr && hit(sfr_addr, CRYSTAL_THERMAL_TRIM_ADDR)) begin
        thermal_ff <= sfr_wdata;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      interval_ff <= REG_RESET_VALUE;
    end else if (sfr_wr && hit(sfr_addr, ALARM_INTERVAL_ADDR)) begin
      interval_ff <= sfr_wdata;
    end
  end

  always_comb begin
    unique case (timebase_t'(timebase_sel))
      TB_FRACTION: itb_tick = frac_tick;
      TB_SECOND:   itb_tick = sec_tick;
      TB_MINUTE:   itb_tick = min_tick;
      TB_HOUR:     itb_tick = hour_tick;
    endcase
  end

  assign nxt_icount = 8'(icount_ff + 8'h01);
  assign alarm_evt  = interval_enable && rtc_enable && !ihold_ff && itb_tick
                    && (nxt_icount == interval_ff);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      icount_ff <= '0;
      ihold_ff  <= 1'b0;
    end else if (mcu_rst || !interval_enable || !rtc_enable) begin
      icount_ff <= '0;
      ihold_ff  <= 1'b0;
    end else if (alarm_evt) begin
      icount_ff <= '0;
      ihold_ff  <= single_shot_alarm;
    end else if (itb_tick && !ihold_ff) begin
      icount_ff <= nxt_icount;
    end
  end

  // set beats a clear in the same cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rollover_ff <= 1'b0;
      alarm_ff    <= 1'b0;
    end else begin
      if (midnight_evt) begin
        rollover_ff <= 1'b1;
      end else if (day_rollover_clr || mcu_rst) begin
        rollover_ff <= 1'b0;
      end
      if (alarm_evt) begin
        alarm_ff <= 1'b1;
      end else if (alarm_clr || mcu_rst) begin
        alarm_ff <= 1'b0;
      end
    end
  end

  // pending request pulse for the interrupt controller, one cycle; a rollover and an alarm in the same cycle share one pulse
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= midnight_evt | alarm_evt;
    end
  end

  always_comb begin
    nxt_rdata = 8'h00;
    unique case (1'b1)
      hit(sfr_addr, LOWER_TIME_UNIT_ADDR):      nxt_rdata = lower_ff;
      hit(sfr_addr, MIDDLE_TIME_UNIT_ADDR):     nxt_rdata = middle_ff;
      hit(sfr_addr, UPPER_TIME_UNIT_ADDR):      nxt_rdata = upper_ff;
      hit(sfr_addr, ALARM_INTERVAL_ADDR):       nxt_rdata = interval_ff;
      hit(sfr_addr, CRYSTAL_NOMINAL_TRIM_ADDR): nxt_rdata = nominal_ff;
      hit(sfr_addr, CRYSTAL_THERMAL_TRIM_ADDR): nxt_rdata = thermal_ff;
      default:                                  nxt_rdata = 8'h00;
    endcase
  end

  // read data lags the address by one clock
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  rtc_trim_sum u_trim_sum (
    .clk             (clk),
    .sys_rst         (sys_rst),
    .nominal_trim    (nominal_ff),
    .thermal_trim    (thermal_ff),
    .trim_correction (trim_correction)
  );

  assign sfr_rdata           = rdata_ff;
  assign day_rollover_flag   = rollover_ff;
  assign alarm_flag          = alarm_ff;
  assign rtc_irq_pending     = irq_ff;
  assign fraction_tick_count = fraction_ff;

  a_sec_wrap: assert property (@(posedge clk) disable iff (sys_rst)
    sec_tick && lower_ff == MINSEC_LAST && rtc_enable && !sfr_wr
      |=> lower_ff == 8'h00)
    else $error("seconds did not wrap to zero");
  a_sec_carry: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(middle_ff) && $past(rtc_enable) && !$past(sfr_wr)
      |-> $past(lower_ff) == MINSEC_LAST)
    else $error("minutes moved without seconds carry");
  a_hour24_wrap: assert property (@(posedge clk) disable iff (sys_rst)
    day_mode_select && hour_tick && upper_ff == HOUR24_LAST && !sfr_wr
      |=> upper_ff == 8'h00 && rollover_ff && irq_ff)
    else $error("24 hour rollover wrong");
  a_hour256_wrap: assert property (@(posedge clk) disable iff (sys_rst)
    !day_mode_select && hour_tick && upper_ff == HOUR256_LAST && !sfr_wr
      |=> upper_ff == 8'h00 && rollover_ff && irq_ff)
    else $error("256 hour rollover wrong");
  a_time_keep: assert property (@(posedge clk) disable iff (sys_rst)
    mcu_rst && rtc_enable && !sfr_wr && !sec_tick |=> $stable(lower_ff))
    else $error("seconds lost on mcu reset");
  a_alarm_set: assert property (@(posedge clk) disable iff (sys_rst)
    alarm_evt |=> alarm_ff && irq_ff && icount_ff == 8'h00)
    else $error("alarm event not flagged");
  a_single_hold: assert property (@(posedge clk) disable iff (sys_rst)
    alarm_evt && single_shot_alarm && !mcu_rst
      |=> ihold_ff ##1 (icount_ff == 8'h00))
    else $error("single shot counter not held");
  a_frac_carry: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(fraction_ff == 8'h00) && $past(rtc_enable)
      |-> $past(fraction_ff) == FRACTION_LAST)
    else $error("fraction counter wrapped wrong");
  a_sfr_read: assert property (@(posedge clk) disable iff (sys_rst)
    sfr_wr && hit(sfr_addr, ALARM_INTERVAL_ADDR) ##1 !sfr_wr && hit(sfr_addr, ALARM_INTERVAL_ADDR)
      |=> sfr_rdata == $past(sfr_wdata, 2))
    else $error("alarm interval readback wrong");
  a_tb_select: assert property (@(posedge clk) disable iff (sys_rst)
    timebase_sel == 2'b00 |-> itb_tick == frac_tick)
    else $error("fraction timebase not selected");
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// self-checking bench for the rtc time counters, interval alarm and trims
// assumes the design alone; inputs change at the falling edge of a 4 ns clock
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] %0t got %0h expected %0h", $time, a, b); end end
module tb_top;
  import rtc_time_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        mcu_rst = 1'b0;
  logic        cal_clk_32k = 1'b0;
  logic [7:0]  sfr_addr = 8'h00;
  logic        sfr_wr = 1'b0;
  logic [7:0]  sfr_wdata = 8'h00;
  logic [7:0]  sfr_rdata;
  logic        rtc_enable = 1'b0;
  logic        interval_enable = 1'b0;
  logic        day_mode_select = 1'b0;
  logic [1:0]  timebase_sel = TB_SECOND;
  logic        single_shot_alarm = 1'b0;
  logic        day_rollover_clr = 1'b0;
  logic        alarm_clr = 1'b0;
  logic        day_rollover_flag;
  logic        alarm_flag;
  logic        rtc_irq_pending;
  logic [7:0]  fraction_tick_count;
  logic signed [7:0] trim_correction;
  logic [7:0]  addr_tab [6] = '{LOWER_TIME_UNIT_ADDR, MIDDLE_TIME_UNIT_ADDR,
    UPPER_TIME_UNIT_ADDR, ALARM_INTERVAL_ADDR, CRYSTAL_NOMINAL_TRIM_ADDR,
    CRYSTAL_THERMAL_TRIM_ADDR};
  int          lim_tab [6] = '{60, 60, 24, 256, 256, 256};
  int          m_reg [6] = '{0, 0, 0, 0, 0, 0};
  int          m_frac = 0;
  int          m_cnt = 0;
  int          m_hold = 0;
  int          m_alarm = 0;
  int          m_irq = 0;
  int          irq_seen = 0;
  int          seed = 13;
  int          bad_count = 0;
  int          checks = 0;
  int          cyc = 0;

  rtc_time_counters_alarm DUT (
    .clk(clk), .sys_rst(sys_rst), .mcu_rst(mcu_rst), .cal_clk_32k(cal_clk_32k),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .rtc_enable(rtc_enable), .interval_enable(interval_enable),
    .day_mode_select(day_mode_select), .timebase_sel(timebase_sel),
    .single_shot_alarm(single_shot_alarm), .day_rollover_clr(day_rollover_clr),
    .alarm_clr(alarm_clr), .day_rollover_flag(day_rollover_flag),
    .alarm_flag(alarm_flag), .rtc_irq_pending(rtc_irq_pending),
    .fraction_tick_count(fraction_tick_count), .trim_correction(trim_correction)
  );

  always #2 clk = ~clk;

  // a stuck pulse overcounts here, so the one-cycle width is checked too
  always @(negedge clk) begin
    if (rtc_irq_pending === 1'b1) irq_seen++;
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      close_out;
    end
  end

  task automatic close_out;
    if (bad_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    // time registers stay cleared while the rtc is stopped
    foreach (addr_tab[i])
      if (addr_tab[i] == a && (i > 2 || rtc_enable)) m_reg[i] = int'(d);
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input int e);
    @(negedge clk);
    sfr_addr = a;
    @(negedge clk);
    `CHK(sfr_rdata, 8'(e))
  endtask

  task automatic rd_all;
    foreach (addr_tab[i]) rd(addr_tab[i], m_reg[i]);
  endtask

  task automatic trim(input int n, input int t);
    int s;
    s = n + t;
    if (s > 124) s = 124;
    if (s < -124) s = -124;
    wr(CRYSTAL_NOMINAL_TRIM_ADDR, 8'(n));
    wr(CRYSTAL_THERMAL_TRIM_ADDR, 8'(t));
    repeat (3) @(negedge clk);
    `CHK(trim_correction, 8'(s))
  endtask

  // 256 calibrated ticks make one 1/128 s step
  task automatic frac_tick;
    repeat (256) begin
      @(negedge clk);
      cal_clk_32k = 1'b1;
      repeat (3) @(negedge clk);
      cal_clk_32k = 1'b0;
      repeat (2) @(negedge clk);
    end
    repeat (4) @(negedge clk);
    m_frac = (m_frac + 1) % 128;
    if (interval_enable && timebase_sel == TB_FRACTION && m_hold == 0) begin
      m_cnt = (m_cnt + 1) % 256;
      if (m_cnt == m_reg[3]) begin
        m_cnt = 0;
        m_alarm = 1;
        m_irq++;
        m_hold = int'(single_shot_alarm);
      end
    end
    `CHK(fraction_tick_count, 8'(m_frac))
    `CHK(alarm_flag, 1'(m_alarm))
    `CHK(irq_seen, m_irq)
  endtask

  initial begin
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    rd_all;
    rd(8'ha2, 0);
    wr(LOWER_TIME_UNIT_ADDR, 8'h11);
    rd(LOWER_TIME_UNIT_ADDR, 0);
    rtc_enable = 1'b1;
    interval_enable = 1'b1;
    foreach (addr_tab[i]) wr(addr_tab[i], 8'($unsigned($random(seed)) % lim_tab[i]));
    rd_all;
    trim(127, 127);
    trim(-128, -128);
    repeat (6) trim($random(seed) % 128, $random(seed) % 128);
    wr(ALARM_INTERVAL_ADDR, 8'h01);
    frac_tick;
    timebase_sel = TB_FRACTION;
    wr(ALARM_INTERVAL_ADDR, 8'h02);
    repeat (2) frac_tick;
    @(negedge clk);
    alarm_clr = 1'b1;
    day_rollover_clr = 1'b1;
    @(negedge clk);
    alarm_clr = 1'b0;
    day_rollover_clr = 1'b0;
    m_alarm = 0;
    repeat (2) frac_tick;
    @(negedge clk);
    mcu_rst = 1'b1;
    @(negedge clk);
    mcu_rst = 1'b0;
    m_alarm = 0;
    m_cnt = 0;
    m_hold = 0;
    @(negedge clk);
    `CHK(alarm_flag, 1'b0)
    `CHK(day_rollover_flag, 1'b0)
    rd_all;
    timebase_sel = TB_MINUTE;
    day_mode_select = 1'b1;
    frac_tick;
    timebase_sel = TB_HOUR;
    frac_tick;
    timebase_sel = TB_FRACTION;
    single_shot_alarm = 1'b1;
    repeat (4) frac_tick;
    @(negedge clk);
    sys_rst = 1'b1;
    @(negedge clk);
    sys_rst = 1'b0;
    m_reg = '{0, 0, 0, 0, 0, 0};
    m_frac = 0;
    rd_all;
    `CHK(fraction_tick_count, 8'h00)
    close_out;
  end
endmodule
`default_nettype wire
